/* hdl/config_bus_width_sync_detect.sv */
`timescale 1ns/1ps
module config_bus_width_sync_detect (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic config_clock,
  input wire logic [31:0] pin_data,
  input wire logic port_write_sel,
  input wire logic parallel_mode,
  input wire logic program_pulse,
  input wire logic scan_reprogram_command,
  input wire logic internal_reprogram_command,
  output cfg_width_sync_pkg::width_e bus_width,
  output logic width_locked,
  output logic sync_found,
  output logic [31:0] word_data,
  output logic word_valid
);
  import cfg_width_sync_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [2:0] config_clock_sync_reg;
  logic [1:0] sel_sync_reg, par_sync_reg;
  logic [2:0] rst_s1_reg, rst_s2_reg;
  logic [31:0] data_s1_reg, data_s2_reg;
  wire [2:0] restart_raw = {internal_reprogram_command, scan_reprogram_command, program_pulse};

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      config_clock_sync_reg <= 3'h0;
      sel_sync_reg <= 2'h0;
      par_sync_reg <= 2'h0;
      rst_s1_reg <= 3'h0;
      rst_s2_reg <= 3'h0;
    end else begin
      config_clock_sync_reg <= {config_clock_sync_reg[1:0], config_clock};
      sel_sync_reg <= {sel_sync_reg[0], port_write_sel};
      par_sync_reg <= {par_sync_reg[0], parallel_mode};
      rst_s1_reg <= restart_raw;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_s1_reg <= SHIFT_RST;
      data_s2_reg <= SHIFT_RST;
    end else begin
      data_s1_reg <= pin_data;
      data_s2_reg <= data_s1_reg;
    end
  end

  wire restart = |rst_s2_reg;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++) rev8[i] = b[7 - i];
  endfunction

  function automatic logic [31:0] rev_bytes(input logic [31:0] w);
    rev_bytes = {rev8(w[31:24]), rev8(w[23:16]), rev8(w[15:8]), rev8(w[7:0])};
  endfunction

  det_state_e state_reg, state_next;
  width_e width_reg, width_next;
  logic [31:0] shift_reg, shift_next;
  logic [1:0] cnt_reg, cnt_next;
  logic sync_reg, sync_next;
  logic [31:0] word_reg;
  logic valid_reg;

  wire config_clock_rise = config_clock_sync_reg[1] & ~config_clock_sync_reg[2];
  wire sample = config_clock_rise & sel_sync_reg[1];
  wire [7:0] low_byte = data_s2_reg[7:0];
  wire mark_hit = (low_byte == PAT_MARK);
  // Pin sync pattern is the stream with bit-reversed bytes
  wire [31:0] sync_pins = rev_bytes(SYNC_WORD);
  wire [31:0] shift_in8 = {shift_reg[23:0], data_s2_reg[7:0]};
  wire [31:0] shift_in16 = {shift_reg[15:0], data_s2_reg[15:0]};
  wire [31:0] assembled = (width_reg == WIDTH_X8) ? shift_in8 :
                          (width_reg == WIDTH_X16) ? shift_in16 : data_s2_reg;
  wire [1:0] beats = (width_reg == WIDTH_X8) ? BEATS_X8 :
                     (width_reg == WIDTH_X16) ? BEATS_X16 : BEATS_X32;
  wire word_done = (cnt_reg == beats);

  // ----------------------------------------
  // Width and sync state machine
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    width_next = width_reg;
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    sync_next = sync_reg;
    case (state_reg)
      ST_IDLE: begin
        if (par_sync_reg[1]) begin
          state_next = ST_MARK;
        end
      end
      ST_MARK: begin
        if (!par_sync_reg[1]) begin
          state_next = ST_IDLE;
        end else if (sample && mark_hit) begin
          state_next = ST_CODE;
        end
      end
      ST_CODE: begin
        if (!par_sync_reg[1]) begin
          state_next = ST_IDLE;
        end else if (sample) begin
          state_next = ST_SYNC_HUNT;
          shift_next = SHIFT_RST;
          cnt_next = SYNC_CNT_RST;
          case (low_byte)
            PAT_X8: width_next = WIDTH_X8;
            PAT_X16: width_next = WIDTH_X16;
            PAT_X32: width_next = WIDTH_X32;
            default: state_next = mark_hit ? ST_CODE : ST_MARK;
          endcase
        end
      end
      ST_SYNC_HUNT: begin
        if (sample) begin
          shift_next = assembled;
          if (!sync_reg && assembled == sync_pins) begin
            sync_next = 1'b1;
            cnt_next = SYNC_CNT_RST;
          end else if (sync_reg) begin
            cnt_next = word_done ? SYNC_CNT_RST : cnt_reg + 2'h1;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
    end else if (restart) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      width_reg <= WIDTH_NONE;
    end else if (restart) begin
      width_reg <= WIDTH_NONE;
    end else begin
      width_reg <= width_next;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_reg <= SHIFT_RST;
    end else if (restart) begin
      shift_reg <= SHIFT_RST;
    end else begin
      shift_reg <= shift_next;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= SYNC_CNT_RST;
    end else if (restart) begin
      cnt_reg <= SYNC_CNT_RST;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_reg <= 1'b0;
    end else if (restart) begin
      sync_reg <= 1'b0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  // ----------------------------------------
  // Aligned word output
  // ----------------------------------------
  wire emit = sample && sync_reg && (state_reg == ST_SYNC_HUNT) && word_done;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= emit;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      word_reg <= SHIFT_RST;
    end else if (emit) begin
      word_reg <= rev_bytes(assembled);
    end
  end

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  assign bus_width = width_reg;
  assign width_locked = (state_reg == ST_SYNC_HUNT);
  assign sync_found = sync_reg;
  assign word_data = word_reg;
  assign word_valid = valid_reg;
endmodule

/* hdl/cfg_width_sync_pkg.sv */
// Behaviour
// - Parallel modes detect bus width from pattern
// - Only low eight data lines examined
// - BB then 11 selects x8
// - BB then 22 selects x16
// - BB then 44 selects x32
// - Bad code after BB resumes BB search
// - Valid pair switches width, starts sync search
// - Width locked until power, program, reprogram
// - Serial, scan, SPI modes ignore pattern
// - No sync match before width detected
// - Sync word aligns 32-bit word boundary
// - Words before sync discarded, none processed
// - Sync word is AA 99 55 66
// - Pins carry bits reversed within each byte
// - Byte MSB rides on data line zero
package cfg_width_sync_pkg;
  localparam int DATA_W = 32;
  localparam logic [7:0] PAT_MARK = 8'hBB;
  localparam logic [7:0] PAT_X8 = 8'h11;
  localparam logic [7:0] PAT_X16 = 8'h22;
  localparam logic [7:0] PAT_X32 = 8'h44;
  localparam logic [31:0] SYNC_WORD = 32'hAA995566;
  localparam logic [1:0] SYNC_CNT_RST = 2'h0;
  localparam logic [1:0] BEATS_X8 = 2'h3;
  localparam logic [1:0] BEATS_X16 = 2'h1;
  localparam logic [1:0] BEATS_X32 = 2'h0;
  localparam logic [31:0] SHIFT_RST = 32'h00000000;
  typedef enum logic [1:0] {WIDTH_NONE, WIDTH_X8, WIDTH_X16, WIDTH_X32} width_e;
  typedef enum logic [1:0] {ST_IDLE, ST_MARK, ST_CODE, ST_SYNC_HUNT} det_state_e;
endpackage

/* tb/cfg_host_model.sv */
`timescale 1ns/1ps
module cfg_host_model (
  input wire logic core_clk,
  output logic config_clock,
  output logic [31:0] pin_data
);
  initial {config_clock, pin_data} = 33'h0;
  // One beat, data held across the clock rise
  task automatic beat(input logic [31:0] v);
    pin_data <= v;
    repeat (8) @(posedge core_clk);
    config_clock <= 1'b1;
    repeat (8) @(posedge core_clk);
    config_clock <= 1'b0;
  endtask
  // Released bus shows the inverse
  task automatic rel();
    @(posedge core_clk) pin_data <= ~pin_data;
  endtask
endmodule

/* tb/config_bus_width_sync_detect_props.sv */
`timescale 1ns/1ps
module config_bus_width_sync_detect_props (
  input wire logic core_clk,
  input wire logic arst_n,
  input cfg_width_sync_pkg::width_e bus_width,
  input wire logic width_locked,
  input wire logic sync_found,
  input wire logic [31:0] word_data,
  input wire logic word_valid
);
  import cfg_width_sync_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  chk_lock_code: assert property (width_locked |-> bus_width != WIDTH_NONE) else $error("no width");
  chk_idle_none: assert property (!width_locked |-> bus_width == WIDTH_NONE) else $error("early width");
  chk_width_hold: assert property ($past(width_locked) && width_locked |-> $stable(bus_width)) else $error("moved");
  chk_lock_first: assert property ($rose(width_locked) |-> !sync_found) else $error("sync first");
  chk_sync_lock: assert property (sync_found |-> width_locked) else $error("sync early");
  chk_word_sync: assert property (word_valid |-> sync_found) else $error("word early");
  chk_word_pulse: assert property (word_valid |=> !word_valid) else $error("long valid");
  chk_data_hold: assert property ($changed(word_data) |-> word_valid) else $error("data moved");
  cover property ($rose(sync_found));
  cover property (word_valid);
  cover property ($fell(width_locked));
endmodule
bind config_bus_width_sync_detect config_bus_width_sync_detect_props chk_u (.*);

/* tb/tb_config_bus_width_sync_detect.sv */
`timescale 1ns/1ps
module tb_config_bus_width_sync_detect;
  import cfg_width_sync_pkg::*;
  logic core_clk = 1'b0, arst_n = 1'b0, port_write_sel = 1'b0, parallel_mode = 1'b0;
  logic program_pulse = 1'b0, scan_reprogram_command = 1'b0, internal_reprogram_command = 1'b0;
  logic config_clock, width_locked, sync_found, word_valid;
  logic [31:0] pin_data, word_data, w, exp_q[$];
  logic [31:0] pat[9] = '{32'h5599AA66, 32'h000000BB, 32'h00000077, 32'hFFFFFFFF, 32'h000000BB,
    32'h11220044, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h5599AA66};
  width_e bus_width;
  int err_count = 0, comparisons = 0;
  config_bus_width_sync_detect dut_u (.*);
  cfg_host_model host_u (.*);
  initial forever #5 core_clk = ~core_clk;
  initial begin
    #200us;
    err_count++;
    end_sim();
  end
  task end_sim();
    if (err_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task cmp_word(input logic [31:0] a, e);
    comparisons++;
    err_count += a !== e;
    if (a !== e) $display("[ERR] %0t %h %h", $time, a, e);
  endtask
  task cmp_state(input logic [4:0] a, e);
    comparisons++;
    err_count += a !== e;
    if (a !== e) $display("[ERR] %0t %h %h", $time, a, e);
  endtask
  function automatic logic [31:0] rev(input logic [31:0] p);
    for (int i = 0; i < 32; i++) rev[i] = p[i / 8 * 8 + 7 - i % 8];
  endfunction
  task send(input logic [31:0] p, input int n);
    for (int i = 0; i < n; i++) host_u.beat(p << 32 / n * i >> 32 - 32 / n | $urandom << 32 / n);
  endtask
  task run(input int n, input logic m, input int k);
    {internal_reprogram_command, scan_reprogram_command, program_pulse} <= 3'h1 << k;
    repeat (4) @(posedge core_clk);
    {internal_reprogram_command, scan_reprogram_command, program_pulse} <= 3'h0;
    parallel_mode <= m;
    repeat (4) @(posedge core_clk);
    foreach (pat[i]) send(pat[i], n);
    repeat (6) begin
      port_write_sel <= 1'b0;
      host_u.beat($urandom);
      port_write_sel <= 1'b1;
      w = $urandom;
      if (m) exp_q.push_back(rev(w));
      send(w, n);
    end
    host_u.rel();
    repeat (8) @(posedge core_clk);
    cmp_state({width_locked, bus_width, sync_found, exp_q.size() == 0},
      {m, m ? 2'(n > 2 ? 1 : 4 - n) : 2'h0, m, 1'b1});
  endtask
  always @(posedge core_clk)
    if (word_valid === 1'b1) cmp_word(word_data, exp_q.size() ? exp_q.pop_front() : 32'hX);
  initial begin
    void'($urandom(90265));
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    port_write_sel <= 1'b1;
    for (int t = 0; t < 6; t++) run(t % 3 ? t % 3 : 4, t < 5, t % 3);
    end_sim();
  end
endmodule
